// [tcs_reg_bank.sv]
// Connection status register bank of the Type-C plug-in detector.
`timescale 1ns/10ps
`include "tcs_cfg.svh"
module tcs_reg_bank
  import tcs_pkg::*;
#(
  parameter logic [7:0] CHIP_ID = 8'h5c // Value is arbitrary.
)
(
  input wire logic core_clk, // Core clock, 200 MHz.
  input wire logic reset_n, // Asynchronous reset, active low.
  input wire logic linkClk, // Link-side clock.
  input wire logic sclIn, // Serial clock pin level.
  output logic sclOut, // Serial clock drive level, always low.
  output logic sclOe, // High while stretching serial clock.
  input wire logic sdaIn, // Serial data pin level.
  output logic sdaOut, // Serial data drive level, always low.
  output logic sdaOe, // High while pulling serial data low.
  input wire logic vbusSense, // VBUS present, from the detector.
  input wire logic [2:0] partnerState, // Partner code from detector.
  input wire logic [1:0] ccOrient, // Connected CC line.
  input wire logic [1:0] srcCurrent, // Current advertised by source.
  output logic [1:0] portRole, // Requested port role.
  output logic [1:0] chargeMode, // Current to advertise as source.
  output logic accessoryDetEn, // Accessory detection as sink.
  output logic trySinkSel, // Dual role 2 prefers sink.
  output logic powerSave, // Low power request.
  output logic irqOutLowOut, // Interrupt pin drive level.
  output logic irqOutLowOe // High while pulling interrupt low.
);

  // ****************************************************************
  // State of the core domain
  // ****************************************************************

  typedef struct packed {
    logic reqMeta;
    logic reqSync;
    logic ackTog;
    logic [7:0] rdData;
    logic [7:0] ctrl;
    logic attachEv;
    logic detachEv;
    logic wasAttached;
    logic [7:0] status;
    logic irqOe;
  } tcs_core_t;

  localparam tcs_core_t CORE_RST = '{
    ctrl: `TCS_CTRL_RST,
    status: `TCS_STAT_RST,
    attachEv: `TCS_EVT_RST,
    detachEv: `TCS_EVT_RST,
    default: '0
  };

  tcs_core_t r;
  tcs_core_t n;

  // ****************************************************************
  // Link front end
  // ****************************************************************

  logic reqTog;
  logic reqWrite;
  logic [2:0] reqIdx;
  logic [7:0] reqData;

  // The front end owns the pins; data crosses by toggle handshake.
  tcs_i2c_link uLink (
    .linkClk(linkClk),
    .reset_n(reset_n),
    .sclIn(sclIn),
    .sclOe(sclOe),
    .sdaIn(sdaIn),
    .sdaOe(sdaOe),
    .reqTog(reqTog),
    .reqWrite(reqWrite),
    .reqIdx(reqIdx),
    .reqData(reqData),
    .ackTog(r.ackTog),
    .rdData(r.rdData)
  );

  // ****************************************************************
  // Decode of the detector inputs
  // ****************************************************************

  logic attachedNow;
  logic sinkSide;
  logic accNow;
  logic serve;
  logic setAttach;
  logic setDetach;
  logic clrEvents;
  logic [7:0] statNext;

  // Out-of-range partner codes count as standby and are never shown.
  assign attachedNow = tcs_attached(partnerState);
  assign sinkSide = (partnerState == PT_SOURCE);
  assign accNow = tcs_accessory(partnerState);

  // A pending request is seen once its toggle reaches the second stage.
  assign serve = (r.reqSync != r.ackTog);

  // Edges of the attached condition raise the two event flags.
  assign setAttach = attachedNow && !r.wasAttached;
  assign setDetach = !attachedNow && r.wasAttached;

  // Only a read of the event register clears the flags.
  assign clrEvents = serve && !reqWrite && (reqIdx == `TCS_IDX_EVT);

  // Status byte assembly.
  always_comb begin
    statNext = `TCS_STAT_RST;
    // VBUS is only meaningful when the partner powers us.
    statNext[`TCS_ST_VBUS] = vbusSense && (sinkSide || accNow);
    if (sinkSide) begin
      statNext[`TCS_ST_CUR] = srcCurrent;
    end else begin
      statNext[`TCS_ST_CUR] = `TCS_CUR_STBY;
    end
    if (attachedNow) begin
      statNext[`TCS_ST_PART] = partnerState;
      if (accNow) begin
        statNext[`TCS_ST_ORI] = `TCS_ORI_UNK;
      end else if (ccOrient == `TCS_ORI_CC1 ||
                   ccOrient == `TCS_ORI_CC2) begin
        statNext[`TCS_ST_ORI] = ccOrient;
      end else begin
        // Attached but no line resolved: report undetermined.
        statNext[`TCS_ST_ORI] = `TCS_ORI_UNK;
      end
    end else begin
      statNext[`TCS_ST_PART] = PT_STANDBY;
      statNext[`TCS_ST_ORI] = `TCS_ORI_NONE;
    end
  end

  // ****************************************************************
  // Register access and event logic
  // ****************************************************************

  // Next state of the core domain.
  always_comb begin
    n = r;
    n.reqMeta = reqTog;
    n.reqSync = r.reqMeta;
    n.status = statNext;
    n.wasAttached = attachedNow;
    if (serve) begin
      // Request fields have been stable since the toggle left the link.
      n.ackTog = ~r.ackTog;
      if (reqWrite) begin
        // Only control is writable; other indexes ignore writes.
        if (reqIdx == `TCS_IDX_CTRL) begin
          n.ctrl = reqData;
        end
      end else begin
        unique case (reqIdx)
          `TCS_IDX_ID: n.rdData = CHIP_ID;
          `TCS_IDX_CTRL: n.rdData = r.ctrl;
          `TCS_IDX_EVT: n.rdData = {6'h00, r.detachEv, r.attachEv};
          `TCS_IDX_STAT: n.rdData = r.status;
          default: n.rdData = 8'h00;
        endcase
      end
    end
    // Data is captured before the clear lands; a new event wins.
    n.attachEv = (r.attachEv && !clrEvents) || setAttach;
    n.detachEv = (r.detachEv && !clrEvents) || setDetach;
    // The pin is released in power saving; the other outputs keep following control.
    n.irqOe = (r.attachEv || r.detachEv) &&
              !r.ctrl[`TCS_CTRL_MASK] && !r.ctrl[`TCS_CTRL_PSAVE];
  end

  // Reset takes constants only; the role pin is never consulted.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= CORE_RST;
    end else begin
      r <= n;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************

  // Control fields steer the detector directly.
  assign portRole = r.ctrl[`TCS_CTRL_ROLE];
  assign chargeMode = r.ctrl[`TCS_CTRL_CUR];
  assign accessoryDetEn = r.ctrl[`TCS_CTRL_ACC];
  assign trySinkSel = r.ctrl[`TCS_CTRL_TRY];
  assign powerSave = r.ctrl[`TCS_CTRL_PSAVE];

  // Open-drain pins only ever drive low.
  assign irqOutLowOut = 1'b0;
  assign irqOutLowOe = r.irqOe;
  assign sclOut = 1'b0;
  assign sdaOut = 1'b0;

  // ****************************************************************
  // Checks
  // ****************************************************************

  // Helper flag: low only during the first cycle after reset.
  logic bootSeen;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      bootSeen <= 1'b0;
    end else begin
      bootSeen <= 1'b1;
    end
  end

  property p_vbus_on;
    @(posedge core_clk) disable iff (!reset_n)
    (vbusSense && (sinkSide || accNow)) |=> r.status[7];
  endproperty
  a_vbus_on: assert property (p_vbus_on)
    else $error("VBUS bit not set while sink");

  property p_vbus_off;
    @(posedge core_clk) disable iff (!reset_n)
    (!vbusSense || !(sinkSide || accNow)) |=> !r.status[7];
  endproperty
  a_vbus_off: assert property (p_vbus_off)
    else $error("VBUS bit set when not reportable");

  property p_current;
    @(posedge core_clk) disable iff (!reset_n)
    sinkSide |=> (r.status[6:5] == $past(srcCurrent));
  endproperty
  a_current: assert property (p_current)
    else $error("Current field does not follow source");

  property p_current_idle;
    @(posedge core_clk) disable iff (!reset_n)
    !sinkSide |=> (r.status[6:5] == 2'h0);
  endproperty
  a_current_idle: assert property (p_current_idle)
    else $error("Current field not standby");

  property p_partner;
    @(posedge core_clk) disable iff (!reset_n)
    attachedNow |=> (r.status[4:2] == $past(partnerState));
  endproperty
  a_partner: assert property (p_partner)
    else $error("Partner field wrong");

  property p_partner_max;
    @(posedge core_clk) disable iff (!reset_n)
    (partnerState > 3'h5) |=> (r.status[4:2] == 3'h0);
  endproperty
  a_partner_max: assert property (p_partner_max)
    else $error("Illegal partner code reported");

  property p_orient;
    @(posedge core_clk) disable iff (!reset_n)
    (attachedNow && !accNow &&
     (ccOrient == 2'h1 || ccOrient == 2'h2))
    |=> (r.status[1:0] == $past(ccOrient));
  endproperty
  a_orient: assert property (p_orient)
    else $error("Orientation not reported");

  property p_orient_acc;
    @(posedge core_clk) disable iff (!reset_n)
    accNow |=> (r.status[1:0] == 2'h3);
  endproperty
  a_orient_acc: assert property (p_orient_acc)
    else $error("Accessory orientation not undetermined");

  property p_role_boot;
    @(posedge core_clk) disable iff (!reset_n)
    !bootSeen |-> (portRole == 2'h0 && r.ctrl == 8'h00);
  endproperty
  a_role_boot: assert property (p_role_boot)
    else $error("Port role not sink after reset");

  property p_detach;
    @(posedge core_clk) disable iff (!reset_n)
    (bootSeen && $fell(attachedNow)) |=> r.detachEv;
  endproperty
  a_detach: assert property (p_detach)
    else $error("Detach flag not set");

  property p_attach;
    @(posedge core_clk) disable iff (!reset_n)
    (bootSeen && $rose(attachedNow)) |=> r.attachEv;
  endproperty
  a_attach: assert property (p_attach)
    else $error("Attach flag not set");

  property p_irq;
    @(posedge core_clk) disable iff (!reset_n)
    ((r.attachEv || r.detachEv) && r.ctrl[0] == 1'b0 && !r.ctrl[7])
    |=> irqOutLowOe;
  endproperty
  a_irq: assert property (p_irq)
    else $error("Interrupt pin not pulled low");

  property p_irq_mask;
    @(posedge core_clk) disable iff (!reset_n)
    r.ctrl[0] |=> !irqOutLowOe;
  endproperty
  a_irq_mask: assert property (p_irq_mask)
    else $error("Masked interrupt drives pin");

  property p_clear;
    @(posedge core_clk) disable iff (!reset_n)
    (clrEvents && !setAttach && !setDetach)
    |=> (!r.attachEv && !r.detachEv &&
         r.rdData[1] == $past(r.detachEv) &&
         r.rdData[0] == $past(r.attachEv));
  endproperty
  a_clear: assert property (p_clear)
    else $error("Event read did not return then clear");

  property p_keep;
    @(posedge core_clk) disable iff (!reset_n)
    // Any set must land, including one that meets a clearing read.
    (setAttach |=> r.attachEv) and (setDetach |=> r.detachEv);
  endproperty
  a_keep: assert property (p_keep)
    else $error("Event lost during clearing read");

  property p_standby;
    @(posedge core_clk) disable iff (!reset_n)
    !attachedNow |=> (r.status[6:0] == 7'h00);
  endproperty
  a_standby: assert property (p_standby)
    else $error("Status not standby while unattached");

endmodule // tcs_reg_bank

// [tcs_cfg.svh]
// Register map, field layout and reset values of the Connection_status bank.
`ifndef TCS_CFG_SVH
`define TCS_CFG_SVH
`define TCS_I2C_ADDR 7'h1d
`define TCS_IDX_FIRST 3'h1
`define TCS_IDX_ID 3'h1
`define TCS_IDX_CTRL 3'h2
`define TCS_IDX_EVT 3'h3
`define TCS_IDX_STAT 3'h4
`define TCS_IDX_LAST 3'h7
`define TCS_CTRL_RST 8'h00
`define TCS_EVT_RST 1'h0
`define TCS_STAT_RST 8'h00
`define TCS_CTRL_MASK 0
`define TCS_CTRL_ROLE 2:1
`define TCS_CTRL_CUR 4:3
`define TCS_CTRL_ACC 5
`define TCS_CTRL_TRY 6
`define TCS_CTRL_PSAVE 7
`define TCS_ST_VBUS 7
`define TCS_ST_CUR 6:5
`define TCS_ST_PART 4:2
`define TCS_ST_ORI 1:0
`define TCS_ORI_NONE 2'h0
`define TCS_ORI_CC1 2'h1
`define TCS_ORI_CC2 2'h2
`define TCS_ORI_UNK 2'h3
`define TCS_CUR_STBY 2'h0
`define TCS_BITS_BYTE 4'h8
`endif

// [tcs_pkg.sv]
// Shared types and decode helpers of the Connection_status bank.
package tcs_pkg;
  // Attached-partner codes as reported in the status register.
  typedef enum logic [2:0] {
    PT_STANDBY = 3'h0,
    PT_SINK = 3'h1,
    PT_SOURCE = 3'h2,
    PT_AUDIO = 3'h3,
    PT_DEBUG = 3'h4,
    PT_CABLE_SINK = 3'h5
  } tcs_partner_t;

  // True for every legal code other than standby.
  function automatic logic tcs_attached(input logic [2:0] code);
    return (code != PT_STANDBY) && (code <= PT_CABLE_SINK);
  endfunction

  // True for the two accessory codes.
  function automatic logic tcs_accessory(input logic [2:0] code);
    return (code == PT_AUDIO) || (code == PT_DEBUG);
  endfunction
endpackage

// [tcs_i2c_link.sv]
// I2C slave front end on the link clock, handing accesses to the bank.
`timescale 1ns/10ps
`include "tcs_cfg.svh"
module tcs_i2c_link
  import tcs_pkg::*;
(
  input wire logic linkClk, // Link-side clock.
  input wire logic reset_n, // Asynchronous reset, active low.
  input wire logic sclIn, // Serial clock pin level.
  output logic sclOe, // High while holding serial clock low.
  input wire logic sdaIn, // Serial data pin level.
  output logic sdaOe, // High while pulling serial data low.
  output logic reqTog, // Toggles once per register access.
  output logic reqWrite, // Access is a write.
  output logic [2:0] reqIdx, // Register index of the access.
  output logic [7:0] reqData, // Write data.
  input wire logic ackTog, // Bank answer toggle, crossed here.
  input wire logic [7:0] rdData // Read data, stable once answered.
);
  typedef enum logic [7:0] {
    L_IDLE = 8'h01,
    L_ADDR = 8'h02,
    L_AACK = 8'h04,
    L_WAIT = 8'h08,
    L_WBYTE = 8'h10,
    L_WACK = 8'h20,
    L_RBYTE = 8'h40,
    L_RACK = 8'h80
  } tcs_link_st_t;

  typedef struct packed {
    logic sclMeta, sclSync, sclPrev;
    logic sdaMeta, sdaSync, sdaPrev;
    logic ackMeta, ackSync;
    tcs_link_st_t st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic rnw, mAck;
    logic [2:0] idx;
    logic reqTog, reqWrite;
    logic [2:0] reqIdx;
    logic [7:0] reqData;
    logic sdaOe, sclOe;
  } tcs_link_t;

  localparam tcs_link_t LINK_RST = '{sclMeta: 1'b1, sclSync: 1'b1,
    sclPrev: 1'b1, sdaMeta: 1'b1, sdaSync: 1'b1, sdaPrev: 1'b1,
    st: L_IDLE, idx: `TCS_IDX_FIRST, default: '0};

  tcs_link_t r;
  tcs_link_t n;
  logic rise, fall, startC, stopC;

  // Edges and bus conditions look only at the second and third stages.
  assign rise = !r.sclPrev && r.sclSync;
  assign fall = r.sclPrev && !r.sclSync;
  assign startC = r.sclSync && r.sclPrev && r.sdaPrev && !r.sdaSync;
  assign stopC = r.sclSync && r.sclPrev && !r.sdaPrev && r.sdaSync;

  // Bit engine; serial clock is stretched while the bank answers.
  always_comb begin
    n = r;
    n.sclMeta = sclIn;
    n.sclSync = r.sclMeta;
    n.sclPrev = r.sclSync;
    n.sdaMeta = sdaIn;
    n.sdaSync = r.sdaMeta;
    n.sdaPrev = r.sdaSync;
    n.ackMeta = ackTog;
    n.ackSync = r.ackMeta;
    unique case (r.st)
      L_IDLE: begin
      end
      L_ADDR, L_WBYTE: begin
        if (rise) begin
          n.sh = {r.sh[6:0], r.sdaSync};
          n.cnt = r.cnt + 4'h1;
        end else if (fall && r.cnt == `TCS_BITS_BYTE) begin
          if (r.st == L_WBYTE) begin
            n.reqTog = ~r.reqTog;
            n.reqWrite = 1'b1;
            n.reqIdx = r.idx;
            n.reqData = r.sh;
            n.sclOe = 1'b1;
            n.st = L_WAIT;
          end else if (r.sh[7:1] == `TCS_I2C_ADDR) begin
            n.sdaOe = 1'b1;
            n.rnw = r.sh[0];
            n.st = L_AACK;
          end else begin
            n.st = L_IDLE;
          end
        end
      end
      L_AACK, L_WACK: begin
        if (fall) begin
          n.sdaOe = 1'b0;
          n.cnt = 4'h0;
          n.st = L_WBYTE;
          if (r.st == L_AACK && r.rnw) begin
            n.reqTog = ~r.reqTog;
            n.reqWrite = 1'b0;
            n.reqIdx = r.idx;
            n.sclOe = 1'b1;
            n.st = L_WAIT;
          end
        end
      end
      L_WAIT: begin
        if (r.ackSync == r.reqTog) begin
          n.sclOe = 1'b0;
          if (r.idx != `TCS_IDX_LAST) begin
            n.idx = r.idx + 3'h1;
          end
          if (r.reqWrite) begin
            n.sdaOe = 1'b1;
            n.st = L_WACK;
          end else begin
            n.sh = rdData;
            n.sdaOe = !rdData[7];
            n.cnt = 4'h1;
            n.st = L_RBYTE;
          end
        end
      end
      L_RBYTE: begin
        if (fall && r.cnt == `TCS_BITS_BYTE) begin
          n.sdaOe = 1'b0;
          n.st = L_RACK;
        end else if (fall) begin
          n.sh = {r.sh[6:0], 1'b0};
          n.sdaOe = !r.sh[6];
          n.cnt = r.cnt + 4'h1;
        end
      end
      L_RACK: begin
        if (rise) begin
          n.mAck = !r.sdaSync;
        end else if (fall && r.mAck) begin
          n.reqTog = ~r.reqTog;
          n.reqWrite = 1'b0;
          n.reqIdx = r.idx;
          n.sclOe = 1'b1;
          n.st = L_WAIT;
        end else if (fall) begin
          n.st = L_IDLE;
        end
      end
    endcase
    // A start restarts the walk at the first register.
    if (startC) begin
      n.st = L_ADDR;
      n.cnt = 4'h0;
      n.idx = `TCS_IDX_FIRST;
      n.sdaOe = 1'b0;
    end else if (stopC) begin
      n.st = L_IDLE;
      n.sdaOe = 1'b0;
      n.sclOe = 1'b0;
    end
  end

  // State register of the link domain.
  always_ff @(posedge linkClk or negedge reset_n) begin
    if (!reset_n) begin
      r <= LINK_RST;
    end else begin
      r <= n;
    end
  end

  assign sclOe = r.sclOe;
  assign sdaOe = r.sdaOe;
  assign reqTog = r.reqTog;
  assign reqWrite = r.reqWrite;
  assign reqIdx = r.reqIdx;
  assign reqData = r.reqData;
endmodule // tcs_i2c_link

// [tcs_i2c_host.sv]
// Behavioural I2C host that walks the bank's registers from the first one.
`timescale 1ns/10ps
module tcs_i2c_host (
  input wire logic scl, // Serial clock wire level.
  input wire logic sda, // Serial data wire level.
  output logic mSclOe, // High while the host pulls clock low.
  output logic mSdaOe // High while the host pulls data low.
);
  // Third of a bit; four link clocks so the front end's synchroniser sees it.
  localparam int Q = 120;

  // Both lines are released at time zero and float high on the pull-ups.
  initial begin
    mSclOe = 1'b0;
    mSdaOe = 1'b0;
  end

  // Each access begins at the first register; no offset byte exists.
  task automatic start();
    #Q;
    mSdaOe = 1'b1;
    #Q;
    mSclOe = 1'b1;
  endtask

  // Data rises while the clock is high, then both lines are left released.
  task automatic stop();
    #Q;
    mSdaOe = 1'b1;
    #Q;
    mSclOe = 1'b0;
    #Q;
    mSdaOe = 1'b0;
    #Q;
  endtask

  // One bit; a bounded poll waits out clock stretching by the device.
  task automatic bitx(input logic b, output logic r);
    int n;
    #Q;
    mSdaOe = !b;
    #Q;
    mSclOe = 1'b0;
    n = 0;
    while (!scl && n < 200) begin
      #10;
      n++;
    end
    #Q;
    r = sda;
    mSclOe = 1'b1;
  endtask

  // Eight bits most significant first, then the acknowledge slot.
  task automatic xbyte(input logic [7:0] d, input logic last,
      output logic [7:0] q, output logic nin);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], b);
      q = {q[6:0], b};
    end
    bitx(last, nin);
  endtask
endmodule // tcs_i2c_host

// [tb_top.sv]
// Self-checking bench for the Connection_status register bank.
`timescale 1ns/10ps
module tb_top;
  import tcs_pkg::*;
  localparam logic [7:0] ID = 8'h3a; // Value is arbitrary.
  logic core_clk = 1'b0;
  logic linkClk = 1'b0;
  logic reset_n = 1'b0;
  logic vbusSense = 1'b0;
  logic [2:0] partnerState = 3'h0;
  logic [1:0] ccOrient = 2'h0;
  logic [1:0] srcCurrent = 2'h0;
  logic sclOe, sdaOe, irqOe, hScl, hSda, accEn, trySnk, pwrSave;
  logic sclLvl, sdaLvl, irqLvl;
  logic [1:0] portRole, chargeMode;
  logic [7:0] expQ[$];
  logic [7:0] got;
  logic [7:0] rnd = 8'h41;
  int err_count = 0;
  int checks_done = 0;
  event gotEv;
  // Open-drain wires with pull-ups: low whenever any party pulls.
  wire scl = !(sclOe | hScl);
  wire sda = !(sdaOe | hSda);
  wire irqPin = !irqOe;

  // Core clock and a link clock offset so the two never line up.
  always #2.5 core_clk = ~core_clk;
  initial begin
    #3.3;
    forever #15 linkClk = ~linkClk;
  end

  tcs_reg_bank #(.CHIP_ID(ID)) i_dut (.core_clk(core_clk),
    .reset_n(reset_n), .linkClk(linkClk), .sclIn(scl), .sclOut(sclLvl),
    .sclOe(sclOe), .sdaIn(sda), .sdaOut(sdaLvl), .sdaOe(sdaOe),
    .vbusSense(vbusSense), .partnerState(partnerState),
    .ccOrient(ccOrient), .srcCurrent(srcCurrent), .portRole(portRole),
    .chargeMode(chargeMode), .accessoryDetEn(accEn),
    .trySinkSel(trySnk), .powerSave(pwrSave), .irqOutLowOut(irqLvl),
    .irqOutLowOe(irqOe));
  tcs_i2c_host i_host (.scl(scl), .sda(sda), .mSclOe(hScl),
    .mSdaOe(hSda));

  // ****************************
  // Checking helpers
  // ****************************
  task automatic chkVal(input logic [7:0] a, input logic [7:0] e);
    checks_done++;
    if (a !== e) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, a, e);
    end
  endtask

  // Each byte read is held against the oldest expectation noted.
  always @(gotEv) chkVal(got, expQ.pop_front());

  task automatic exp4(input logic [7:0] a, b, c, d);
    expQ.push_back(a);
    expQ.push_back(b);
    expQ.push_back(c);
    expQ.push_back(d);
  endtask

  // Status byte worked out from the detector inputs now applied.
  function automatic logic [7:0] stExp();
    logic acc;
    acc = partnerState == 3'h3 || partnerState == 3'h4;
    if (partnerState == 3'h0 || partnerState > 3'h5) return 8'h00;
    return {vbusSense && (partnerState == 3'h2 || acc),
      partnerState == 3'h2 ? srcCurrent : 2'h0, partnerState,
      (acc || ccOrient == 2'h0 || ccOrient == 2'h3) ? 2'h3 : ccOrient};
  endfunction

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // Detector inputs change just after the core clock edge.
  task automatic drive(input logic [2:0] p);
    rnd = lfsr(rnd);
    @(posedge core_clk);
    #1;
    partnerState = p;
    vbusSense = rnd[0];
    srcCurrent = rnd[2:1];
    ccOrient = rnd[4:3];
    repeat (4) @(posedge core_clk);
  endtask

  // Reads registers one to n in order, as no offset can be sent.
  task automatic rdRegs(input int n);
    logic [7:0] q;
    logic a;
    i_host.start();
    i_host.xbyte(8'h3b, 1'b1, q, a);
    chkVal({7'h0, a}, 8'h00);
    for (int i = 1; i <= n; i++) begin
      i_host.xbyte(8'hff, i == n, q, a);
      got = q;
      ->gotEv;
    end
    i_host.stop();
  endtask

  // Writes the identification slot, which must ignore it, then control.
  task automatic wrCtrl(input logic [7:0] v);
    logic [7:0] q;
    logic a;
    i_host.start();
    i_host.xbyte(8'h3a, 1'b1, q, a);
    i_host.xbyte(8'hff, 1'b1, q, a);
    i_host.xbyte(v, 1'b1, q, a);
    i_host.stop();
    chkVal({7'h0, a}, 8'h00);
  endtask

  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Main sequence: reset values, every partner code, then masking.
  initial begin
    logic [7:0] v;
    repeat (16) @(posedge core_clk);
    #1;
    reset_n = 1'b1;
    repeat (40) @(posedge core_clk);
    chkVal({6'h0, portRole}, 8'h00);
    // Open-drain drive levels must only ever pull low.
    chkVal({5'h0, sclLvl, sdaLvl, irqLvl}, 8'h00);
    exp4(ID, 8'h00, 8'h00, 8'h00);
    rdRegs(4);
    $display("Test reset values done");
    for (int p = 1; p <= 7; p++) begin
      drive(p[2:0]);
      chkVal({7'h0, irqPin}, {7'h0, p > 5});
      exp4(ID, 8'h00, {7'h0, p <= 5}, stExp());
      rdRegs(4);
      chkVal({7'h0, irqPin}, 8'h01);
      drive(3'h0);
      exp4(ID, 8'h00, {6'h0, p <= 5, 1'b0}, 8'h00);
      rdRegs(4);
    end
    $display("Test partner codes done");
    rnd = lfsr(rnd);
    v = {1'b0, rnd[6:1], 1'b1};
    wrCtrl(v);
    chkVal({pwrSave, trySnk, accEn, chargeMode, portRole, 1'b0},
      {v[7:1], 1'b0});
    drive(3'h2);
    chkVal({7'h0, irqPin}, 8'h01);
    exp4(ID, v, 8'h01, stExp());
    rdRegs(4);
    drive(3'h0);
    chkVal({7'h0, irqPin}, 8'h01);
    wrCtrl(8'h00);
    repeat (4) @(posedge core_clk);
    chkVal({7'h0, irqPin}, 8'h00);
    expQ.push_back(ID);
    expQ.push_back(8'h00);
    expQ.push_back(8'h02);
    rdRegs(3);
    $display("Test mask and control done");
    print_verdict();
  end

  // The traffic takes some 300 us; half as much again means a hang.
  initial begin
    #450000;
    err_count++;
    print_verdict();
  end
endmodule // tb_top
